// ---- xoc_crystal_osc_control.sv ----
// Digital control of the crystal oscillator: register, states, gating.
// Assumes the pad and crystal inputs are synchronous to mclk.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
module xoc_crystal_osc_control #(
	parameter int STARTUP_CYCLES = xoc_pkg::XOC_STARTUP_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [xoc_pkg::XOC_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic osc_enable,
	input wire logic internal_oscillator_select,
	input wire logic stop_mode,
	input wire logic very_low_leakage_stop_wake,
	input wire logic crystal_amplitude_ok,
	input wire logic clock_input_pad,
	output logic crystal_drive_pad_out,
	output logic crystal_drive_pad_oe,
	output logic pads_connected,
	output logic amplifier_enable,
	output logic hysteresis_enable,
	output logic [3:0] load_cap_select,
	output logic raw_crystal_clock,
	output logic startup_count_done,
	output logic osc_clk_out,
	output logic peripheral_ref_clock,
	output xoc_pkg::xoc_state_e osc_state
);
	import xoc_pkg::*;

	// ********************************************
	// Register file
	// ********************************************
	xoc_control_s oscillator_control;
	logic hit_control;
	logic stop_ref_latched;
	logic stop_d;

	function automatic logic decode_control(
		input logic [XOC_ADDR_W-1:0] addr
	);
		decode_control = (addr == XOC_OFF_CONTROL);
	endfunction

	assign hit_control = decode_control(reg_addr);

	// Reset and deep-stop wake both return the register to zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			oscillator_control <= XOC_CONTROL_RESET;
		end else if (very_low_leakage_stop_wake) begin
			oscillator_control <= XOC_CONTROL_RESET;
		end else if (reg_write && hit_control) begin
			// Reserved bits cannot be written
			oscillator_control <= reg_wdata & XOC_CONTROL_WMASK;
		end
	end

	// Read data stand for one cycle only; unmapped reads return zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read && hit_control) begin
			reg_rdata <= oscillator_control & XOC_CONTROL_WMASK;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ********************************************
	// Stop mode handling
	// ********************************************
	// Bit 7 is sampled at stop entry; setting it during stop is too late
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stop_d <= 1'b0;
			stop_ref_latched <= 1'b0;
		end else begin
			stop_d <= stop_mode;
			if (stop_mode && !stop_d) begin
				stop_ref_latched <= oscillator_control.ref_clock_out_enable;
			end
		end
	end

	logic stop_keep;
	logic eff_enable;
	logic ref_before_stop;

	// In the entry cycle the latch is not loaded yet, so use bit 7 itself
	assign ref_before_stop = stop_d ? stop_ref_latched :
		oscillator_control.ref_clock_out_enable;

	// Oscillator survives stop only with both bits set
	assign stop_keep = oscillator_control.ref_clock_out_enable &&
		oscillator_control.ref_clock_stop_retain && ref_before_stop;
	assign eff_enable = osc_enable && (!stop_mode || stop_keep);

	// ********************************************
	// State machine
	// ********************************************
	xoc_state_e next_state;

	always_comb begin
		next_state = osc_state;
		unique case (osc_state)
			XOC_OFF: begin
				if (eff_enable && internal_oscillator_select) begin
					next_state = XOC_STARTUP;
				end else if (eff_enable) begin
					next_state = XOC_EXT_CLOCK;
				end
			end
			XOC_STARTUP: begin
				if (!eff_enable) begin
					next_state = XOC_OFF;
				end else if (!internal_oscillator_select) begin
					next_state = XOC_EXT_CLOCK;
				end else if (startup_count_done) begin
					next_state = XOC_STABLE;
				end
			end
			XOC_STABLE: begin
				if (!eff_enable) begin
					next_state = XOC_OFF;
				end else if (!internal_oscillator_select) begin
					next_state = XOC_EXT_CLOCK;
				end
			end
			XOC_EXT_CLOCK: begin
				if (!eff_enable) begin
					next_state = XOC_OFF;
				end else if (internal_oscillator_select) begin
					next_state = XOC_STARTUP;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_state <= XOC_OFF;
		end else begin
			osc_state <= next_state;
		end
	end

	// ********************************************
	// Raw crystal clock and start-up counter
	// ********************************************
	logic osc_mode;
	logic raw_d;
	logic raw_tick;
	logic counter_clear;

	assign osc_mode = (osc_state == XOC_STARTUP) ||
		(osc_state == XOC_STABLE);

	// Static in off unless the pad path is selected
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			raw_crystal_clock <= 1'b0;
		end else if (osc_mode) begin
			// Amplitude too small to pass the input buffer yet
			raw_crystal_clock <= crystal_amplitude_ok && clock_input_pad;
		end else if (!internal_oscillator_select) begin
			raw_crystal_clock <= clock_input_pad;
		end else begin
			raw_crystal_clock <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			raw_d <= 1'b0;
		end else begin
			raw_d <= raw_crystal_clock;
		end
	end

	assign raw_tick = raw_crystal_clock && !raw_d;
	// Leaving the oscillator states forces a fresh count
	assign counter_clear = !(osc_mode && next_state != XOC_OFF &&
		next_state != XOC_EXT_CLOCK);

	xoc_startup_counter #(
		.COUNT(STARTUP_CYCLES)
	) u_counter (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(counter_clear),
		.tick(raw_tick && osc_state == XOC_STARTUP),
		.done(startup_count_done)
	);

	// ********************************************
	// Output clocks
	// ********************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_clk_out <= 1'b0;
		end else if (osc_state == XOC_STABLE && next_state == XOC_STABLE) begin
			osc_clk_out <= raw_crystal_clock;
		end else if (osc_state == XOC_EXT_CLOCK &&
			next_state == XOC_EXT_CLOCK) begin
			osc_clk_out <= clock_input_pad;
		end else begin
			osc_clk_out <= 1'b0;
		end
	end

	logic ref_allowed;

	// In stop the reference clock needs bit 5 and bit 7 set beforehand
	assign ref_allowed = oscillator_control.ref_clock_out_enable &&
		(!stop_mode || (oscillator_control.ref_clock_stop_retain &&
		ref_before_stop));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_ref_clock <= 1'b0;
		end else if (ref_allowed) begin
			peripheral_ref_clock <= osc_clk_out;
		end else begin
			peripheral_ref_clock <= 1'b0;
		end
	end

	// ********************************************
	// Pads and analog controls
	// ********************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			load_cap_select <= 4'h0;
		end else begin
			// Index 0..3 map to 2, 4, 8 and 16 pF
			load_cap_select <= {oscillator_control.load_cap_sixteen,
				oscillator_control.load_cap_eight,
				oscillator_control.load_cap_four,
				oscillator_control.load_cap_two};
		end
	end

	// Drive pad only in oscillator mode; free for I/O otherwise
	assign crystal_drive_pad_oe = osc_mode;
	assign crystal_drive_pad_out = osc_mode && !clock_input_pad;
	assign amplifier_enable = osc_mode;
	assign hysteresis_enable = (osc_state == XOC_EXT_CLOCK);
	assign pads_connected = (osc_state != XOC_OFF);
	// No reset request port exists on this block
endmodule

// ---- xoc_pkg.sv ----
// Constants and types shared by the crystal oscillator control logic.
// Assumes one 100 MHz clock and a plain strobe register port.
package xoc_pkg;

	// ********************************************
	// Register map
	// ********************************************
	localparam int XOC_ADDR_W = 4;
	localparam logic [XOC_ADDR_W-1:0] XOC_OFF_CONTROL = 4'h0;
	localparam logic [7:0] XOC_CONTROL_RESET = 8'h00;
	// Writable bits; 6 and 4 stay zero
	localparam logic [7:0] XOC_CONTROL_WMASK = 8'hAF;

	// ********************************************
	// Field positions
	// ********************************************
	localparam int XOC_BIT_REF_EN = 7;
	localparam int XOC_BIT_RSV6 = 6;
	localparam int XOC_BIT_RETAIN = 5;
	localparam int XOC_BIT_RSV4 = 4;
	localparam int XOC_BIT_CAP_TWO = 3;
	localparam int XOC_BIT_CAP_FOUR = 2;
	localparam int XOC_BIT_CAP_EIGHT = 1;
	localparam int XOC_BIT_CAP_SIXTEEN = 0;

	// ********************************************
	// Timing
	// ********************************************
	localparam int XOC_STARTUP_CYCLES = 4096;
	localparam int XOC_CLK_PERIOD_NS = 10;

	typedef enum logic [1:0] {
		XOC_OFF,
		XOC_STARTUP,
		XOC_STABLE,
		XOC_EXT_CLOCK
	} xoc_state_e;

	typedef struct packed {
		logic ref_clock_out_enable;
		logic rsv6;
		logic ref_clock_stop_retain;
		logic rsv4;
		logic load_cap_two;
		logic load_cap_four;
		logic load_cap_eight;
		logic load_cap_sixteen;
	} xoc_control_s;

endpackage

// ---- xoc_startup_counter.sv ----
// Start-up counter that qualifies the raw crystal clock.
// Assumes tick is a one-cycle pulse per raw crystal clock rising edge.
`timescale 1ns/1ns
module xoc_startup_counter #(
	parameter int COUNT = xoc_pkg::XOC_STARTUP_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic tick,
	output logic done
);
	import xoc_pkg::*;

	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	logic [CW-1:0] count;

	// Held at zero while the oscillator is not generating clocks
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (tick && !done) begin
			count <= count + CW'(1);
		end
	end

	// Done once the count has seen every required edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else if (clear) begin
			done <= 1'b0;
		end else if (tick && count == LAST) begin
			done <= 1'b1;
		end
	end
endmodule

// ---- xoc_osc_props.sv ----
// Checker on the oscillator control ports.
// Assumes it is bound to each control instance.
`timescale 1ns/1ns
module xoc_osc_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic osc_enable,
	input wire logic internal_oscillator_select,
	input wire logic stop_mode,
	input wire logic clock_input_pad,
	input wire logic pads_connected,
	input wire logic amplifier_enable,
	input wire logic startup_count_done,
	input wire logic osc_clk_out,
	input wire logic peripheral_ref_clock,
	input wire xoc_pkg::xoc_state_e osc_state
);
	import xoc_pkg::*;
	wire go = osc_enable && !stop_mode;
	wire sel = internal_oscillator_select;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_off_isolated: assert property (
		osc_state == XOC_OFF |-> !pads_connected && !amplifier_enable)
		else $error("pads live while off");
	a_start_entry: assert property (
		osc_state == XOC_OFF && go && sel |=> osc_state == XOC_STARTUP)
		else $error("no start-up");
	a_ext_entry: assert property (
		osc_state == XOC_OFF && go && !sel |=> osc_state == XOC_EXT_CLOCK)
		else $error("no external mode");
	a_ext_buffer: assert property (
		osc_state == XOC_EXT_CLOCK && $past(osc_state) == XOC_EXT_CLOCK
		|-> osc_clk_out == $past(clock_input_pad))
		else $error("pad clock not passed");
	a_startup_gated: assert property (
		osc_state == XOC_STARTUP |-> !osc_clk_out)
		else $error("clock leaks in start-up");
	a_done_stable: assert property (
		osc_state == XOC_STARTUP && startup_count_done && go && sel
		|=> osc_state == XOC_STABLE)
		else $error("no stable state");
	a_ref_source: assert property (
		peripheral_ref_clock |-> $past(osc_clk_out))
		else $error("reference clock not from output");
	a_loss_gates: assert property (
		osc_state inside {XOC_STARTUP, XOC_STABLE} && !osc_enable
		|=> !osc_clk_out && osc_state == XOC_OFF)
		else $error("output not gated on loss");
	a_rsv_zero: assert property (
		reg_read |=> !reg_rdata[6] && !reg_rdata[4])
		else $error("reserved bit set");
	c_stable: cover property (osc_state == XOC_STABLE);
	c_ext: cover property (osc_state == XOC_EXT_CLOCK);
	c_ref: cover property (peripheral_ref_clock);
endmodule

bind xoc_crystal_osc_control xoc_osc_props props_u (
	.mclk(mclk),
	.rst_n(rst_n),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.osc_enable(osc_enable),
	.internal_oscillator_select(internal_oscillator_select),
	.stop_mode(stop_mode),
	.clock_input_pad(clock_input_pad),
	.pads_connected(pads_connected),
	.amplifier_enable(amplifier_enable),
	.startup_count_done(startup_count_done),
	.osc_clk_out(osc_clk_out),
	.peripheral_ref_clock(peripheral_ref_clock),
	.osc_state(osc_state)
);

// ---- xoc_crystal_model.sv ----
// Crystal or external clock source on the pads.
// Assumes amp_on is the block's amplifier enable.
`timescale 1ns/1ns
module xoc_crystal_model (
	input wire logic mclk,
	input wire logic amp_on,
	input wire logic ext_on,
	input wire logic slow,
	output logic pad,
	output logic amp_ok
);
	logic [1:0] div = 2'h0;
	logic [1:0] grow = 2'h0;
	initial pad = 1'b0;
	initial amp_ok = 1'b0;
	// A crystal without drive does not swing, so the pad stays put
	always @(posedge mclk) begin
		div <= div + 2'h1;
		if ((amp_on || ext_on) && (!slow || div == 2'h3))
			pad <= ~pad;
	end
	// Amplitude builds up over a few cycles after drive starts
	always @(posedge mclk) begin
		grow <= amp_on ? grow + {1'b0, grow != 2'h3} : 2'h0;
		amp_ok <= amp_on && grow == 2'h3;
	end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the oscillator control block.
// Assumes the crystal model stands on the pads.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
	n_errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
	import xoc_pkg::*;
	logic mclk, rst_n, reg_write, reg_read, osc_enable, stop_mode;
	logic internal_oscillator_select, very_low_leakage_stop_wake;
	logic crystal_amplitude_ok, clock_input_pad, crystal_drive_pad_out;
	logic crystal_drive_pad_oe, pads_connected, amplifier_enable;
	logic hysteresis_enable, raw_crystal_clock, startup_count_done;
	logic osc_clk_out, peripheral_ref_clock, ext_on, slow, r, c;
	logic [3:0] reg_addr, load_cap_select;
	logic [7:0] reg_wdata, reg_rdata;
	xoc_state_e osc_state;
	int n_errors = 0;
	int check_count = 0;
	xoc_crystal_osc_control #(.STARTUP_CYCLES(8)) dut_u (
		.mclk(mclk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.osc_enable(osc_enable),
		.internal_oscillator_select(internal_oscillator_select),
		.stop_mode(stop_mode),
		.very_low_leakage_stop_wake(very_low_leakage_stop_wake),
		.crystal_amplitude_ok(crystal_amplitude_ok),
		.clock_input_pad(clock_input_pad),
		.crystal_drive_pad_out(crystal_drive_pad_out),
		.crystal_drive_pad_oe(crystal_drive_pad_oe),
		.pads_connected(pads_connected),
		.amplifier_enable(amplifier_enable),
		.hysteresis_enable(hysteresis_enable),
		.load_cap_select(load_cap_select),
		.raw_crystal_clock(raw_crystal_clock),
		.startup_count_done(startup_count_done),
		.osc_clk_out(osc_clk_out),
		.peripheral_ref_clock(peripheral_ref_clock),
		.osc_state(osc_state)
	);
	xoc_crystal_model part_u (.mclk(mclk), .amp_on(amplifier_enable),
		.ext_on(ext_on), .slow(slow), .pad(clock_input_pad),
		.amp_ok(crystal_amplitude_ok));
	// ******
	// Bus and wait tasks
	// ******
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		// Read data stand only in this cycle; take them once settled
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task automatic wait_st(input xoc_state_e s);
		for (int i = 0; i < 200 && osc_state !== s; i++) @(posedge mclk);
		`CHK("state", s, osc_state)
		if (osc_state !== s) give_verdict();
	endtask
	task automatic watch(input int n);
		r = 0;
		c = 0;
		repeat (n) begin
			@(posedge mclk);
			r |= peripheral_ref_clock;
			c |= osc_clk_out;
		end
	endtask
	// ******
	// Scenarios
	// ******
	task automatic t_regs;
		logic [7:0] d;
		rd(4'h0, d);
		`CHK("reset value", XOC_CONTROL_RESET, d)
		wr(4'h0, 8'hFF);
		rd(4'h0, d);
		`CHK("reserved bits", 8'hAF, d)
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, 8'h08 >> i);
			repeat (2) @(posedge mclk);
			`CHK("load cap", 4'h1 << i, load_cap_select)
		end
		wr(4'h3, 8'hFF);
		rd(4'h0, d);
		`CHK("unmapped write", 8'h01, d)
		rd(4'h3, d);
		`CHK("unmapped read", 8'h00, d)
		wr(4'h0, 8'hAF);
		@(posedge mclk) very_low_leakage_stop_wake <= 1'b1;
		@(posedge mclk) very_low_leakage_stop_wake <= 1'b0;
		rd(4'h0, d);
		`CHK("wake clears", 8'h00, d)
	endtask
	task automatic t_startup;
		int rises;
		logic prev, leak;
		wr(4'h0, 8'h80); // Configured before enabling
		slow <= 1'b1;
		internal_oscillator_select <= 1'b1;
		osc_enable <= 1'b1;
		wait_st(XOC_STARTUP);
		`CHK("drive pad", 1'b1, crystal_drive_pad_oe)
		rises = 0;
		leak = 0;
		prev = raw_crystal_clock;
		for (int i = 0; i < 400 && startup_count_done !== 1'b1; i++) begin
			@(posedge mclk);
			rises += int'(raw_crystal_clock && !prev);
			prev = raw_crystal_clock;
			leak |= osc_clk_out;
		end
		`CHK("edges to done", 8, rises)
		`CHK("gated output", 1'b0, leak)
		wait_st(XOC_STABLE);
		watch(20);
		`CHK("ref running", 1'b1, r)
		wr(4'h0, 8'h00);
		// Let the last reference pulse launched before the write drain
		repeat (2) @(posedge mclk);
		watch(20);
		`CHK("ref gated", 1'b0, r)
		`CHK("output running", 1'b1, c)
	endtask
	task automatic t_stop;
		wr(4'h0, 8'hA0);
		stop_mode <= 1'b1;
		watch(20);
		`CHK("kept in stop", XOC_STABLE, osc_state)
		`CHK("ref in stop", 1'b1, r)
		stop_mode <= 1'b0;
		wr(4'h0, 8'h80);
		stop_mode <= 1'b1;
		wait_st(XOC_OFF);
		watch(10);
		`CHK("ref stopped", 1'b0, r)
		stop_mode <= 1'b0;
		wait_st(XOC_STARTUP);
		`CHK("fresh count", 1'b0, startup_count_done)
		wait_st(XOC_STABLE);
		osc_enable <= 1'b0;
		wait_st(XOC_OFF);
		`CHK("done cleared", 1'b0, startup_count_done)
		`CHK("pads isolated", 1'b0, pads_connected)
	endtask
	task automatic t_ext;
		slow <= 1'b0;
		ext_on <= 1'b1;
		internal_oscillator_select <= 1'b0;
		osc_enable <= 1'b1;
		wait_st(XOC_EXT_CLOCK);
		`CHK("hysteresis", 1'b1, hysteresis_enable)
		`CHK("drive pad free", 1'b0, crystal_drive_pad_oe)
		watch(10);
		`CHK("pad clock out", 1'b1, c)
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		{rst_n, reg_write, reg_read, osc_enable, stop_mode} = 5'h00;
		{internal_oscillator_select, very_low_leakage_stop_wake} = 2'h0;
		{ext_on, slow, reg_addr, reg_wdata} = 14'h0000;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_startup();
		t_stop();
		t_ext();
		give_verdict();
	end
endmodule
